// ===== verilog/link_ctl2_pm_defs.vh
// Constants for the link control 2 and power management capability register bank
`ifndef LINK_CTL2_PM_DEFS_VH
`define LINK_CTL2_PM_DEFS_VH

// ==========================================
// Register indices (byte address = 4 * index)
`define DEVICE_CAPABILITIES_SECOND_IDX 10'h064
`define DEVICE_CONTROL_SECOND_IDX 10'h068
`define DEVICE_STATUS_SECOND_IDX 10'h06a
`define LINK_CAPABILITIES_SECOND_IDX 10'h06c
`define LINK_CONTROL_SECOND_IDX 10'h070
`define LINK_STATUS_SECOND_IDX 10'h072
`define SLOT_CAPABILITIES_SECOND_IDX 10'h074
`define SLOT_CONTROL_SECOND_IDX 10'h078
`define SLOT_STATUS_SECOND_IDX 10'h07a
`define POWER_MGMT_CAPABILITY_HEADER_IDX 10'h0c0

// ==========================================
// Link control second fields
`define TARGET_SPEED_LSB 0
`define TARGET_SPEED_MSB 3
`define ENTER_COMPLIANCE_POS 4
`define AUTONOMOUS_SPEED_DISABLE_POS 5
`define TARGET_SPEED_RESET 4'h0
`define SPEED_GEN1 4'h1
`define SPEED_GEN2 4'h2

// ==========================================
// Power management capability header fields
`define CAP_ID_LSB 0
`define CAP_ID_MSB 7
`define NEXT_PTR_LSB 8
`define NEXT_PTR_MSB 15
`define CAP_VERSION_LSB 16
`define CAP_VERSION_MSB 18
`define PM_CLOCK_REQ_POS 19
`define PM_EVENT_LSB 27
`define PM_EVENT_MSB 31
`define CAP_ID_VALUE 8'h01
`define NEXT_PTR_UPSTREAM 8'h00
`define NEXT_PTR_DOWNSTREAM 8'hd0
`define CAP_VERSION_VALUE 3'h3
`define PM_EVENT_RESET 5'h19

`endif

// ===== verilog/lockable_field.v
// Field register with a strap-dependent default and a write gate
`timescale 1ns/1ns

module lockable_field #(
    parameter WIDTH = 8
) (
    mclk,
    srst,
    load_default,
    default_value,
    wr_en,
    wr_data,
    value_q
);
    input wire mclk;
    input wire srst;
    input wire load_default;
    input wire [WIDTH-1:0] default_value;
    input wire wr_en;
    input wire [WIDTH-1:0] wr_data;
    output reg [WIDTH-1:0] value_q;

    // ==========================================
    // Storage
    // Reset takes a constant; the strap-dependent default lands one edge later
    always @(posedge mclk) begin
        if (srst) begin
            value_q <= {WIDTH{1'b0}};
        end else if (load_default) begin
            value_q <= default_value;
        end else if (wr_en) begin
            value_q <= wr_data;
        end
    end
endmodule // lockable_field

// ===== verilog/link_ctl2_pm_regs.v
// Second-generation capability registers, link control 2 and power management header
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ns
`include "link_ctl2_pm_defs.vh"

// What this block does
// - Downstream port advertises no speed above the target speed field.
// - Compliance entry speed comes from the target speed field on any port.
// - Target speed 1 means 2.5 Gbps, 2 means 5 Gbps, others reserved.
// - Enter-compliance bit is sticky; hot reset with it set enters compliance.
// - With autonomous speed disable set, only speed reductions are allowed.
// - In PCIe 1.1 mode the three link fields read zero, ignore writes.
// - Capability identifier always reads 0x1.
// - Upstream port next-capability pointer defaults to 0x0.
// - Downstream port next-capability pointer defaults to 0xD0.
// - Capability version reads constant 0x3.
// - PM clock requirement bit reads zero.
// - PM event support field defaults to 0b11001.
module link_ctl2_pm_regs #(
    parameter GEN2_CAPABLE = 1'b0
) (
    mclk,
    srst,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    is_downstream,
    pcie11_mode,
    cfg_write_unlock,
    hot_reset,
    speed_change_req,
    speed_change_lower,
    target_speed,
    enter_compliance_bit,
    autonomous_speed_disable,
    advertise_gen1,
    advertise_gen2,
    compliance_gen1,
    compliance_gen2,
    target_speed_reserved,
    compliance_active,
    speed_change_grant,
    speed_change_refused
);
    // ==========================================
    // Clock, reset and register bus
    input wire mclk;
    input wire srst;
    input wire psel;
    input wire penable;
    input wire pwrite;
    input wire [11:0] paddr;
    input wire [31:0] pwdata;
    output reg [31:0] prdata;
    output reg pready;
    output reg pslverr;

    // ==========================================
    // Port straps and modes
    input wire is_downstream;
    input wire pcie11_mode;
    input wire cfg_write_unlock;

    // ==========================================
    // Link training side
    input wire hot_reset;
    input wire speed_change_req;
    input wire speed_change_lower;

    // ==========================================
    // Link control fields and decodes for training
    output reg [3:0] target_speed;
    output reg enter_compliance_bit;
    output reg autonomous_speed_disable;
    output reg advertise_gen1;
    output reg advertise_gen2;
    output reg compliance_gen1;
    output reg compliance_gen2;
    output reg target_speed_reserved;
    output reg compliance_active;
    output reg speed_change_grant;
    output reg speed_change_refused;

    // ==========================================
    // APB handshake
    reg init_q;
    reg [3:0] tls_q;
    reg enter_compliance_bit_q;
    reg autonomous_speed_disable_q;
    reg [31:0] rd_d;
    reg hit_d;
    wire [9:0] word_idx;
    wire access;
    wire wr_commit;
    wire lctl2_wr;
    wire power_mgmt_capability_header_wr;
    wire [7:0] next_ptr_q;
    wire [4:0] pm_event_q;
    wire [7:0] next_ptr_default;
    wire pm_fields_wr;
    wire speed_raise;

    assign word_idx = paddr[11:2];
    assign access = psel & penable;
    // Writes land only at the edge where pready is seen high
    assign wr_commit = access & pready & pwrite & ~pslverr;
    assign lctl2_wr = wr_commit & (word_idx == `LINK_CONTROL_SECOND_IDX);
    assign power_mgmt_capability_header_wr = wr_commit & (word_idx == `POWER_MGMT_CAPABILITY_HEADER_IDX);
    assign next_ptr_default = is_downstream ? `NEXT_PTR_DOWNSTREAM : `NEXT_PTR_UPSTREAM;
    // Capability fields behind the write lock share one gate
    assign pm_fields_wr = power_mgmt_capability_header_wr & cfg_write_unlock;
    // A request is a raise unless it is marked as a reduction
    assign speed_raise = speed_change_req & ~speed_change_lower;

    // ==========================================
    // Always-zero register match
    // One comparator per entry; the list is packed ten bits to an entry
    // A table keeps the map in one place, so adding a register is one line plus a ZERO_REG_COUNT bump
    localparam ZERO_REG_COUNT = 8;
    localparam [10*ZERO_REG_COUNT-1:0] ZERO_REG_LIST = {
        `SLOT_STATUS_SECOND_IDX,
        `SLOT_CONTROL_SECOND_IDX,
        `SLOT_CAPABILITIES_SECOND_IDX,
        `LINK_STATUS_SECOND_IDX,
        `LINK_CAPABILITIES_SECOND_IDX,
        `DEVICE_STATUS_SECOND_IDX,
        `DEVICE_CONTROL_SECOND_IDX,
        `DEVICE_CAPABILITIES_SECOND_IDX
    };
    wire [ZERO_REG_COUNT-1:0] zero_hit;
    wire zero_reg_hit;
    genvar zi;

    generate
        for (zi = 0; zi < ZERO_REG_COUNT; zi = zi + 1) begin : zero_match
            assign zero_hit[zi] = (word_idx == ZERO_REG_LIST[10*zi +: 10]);
        end
    endgenerate
    assign zero_reg_hit = |zero_hit;

    // ==========================================
    // Read decode
    always @* begin
        rd_d = 32'h0000_0000;
        hit_d = 1'b1;
        case (word_idx)
            `LINK_CONTROL_SECOND_IDX: begin
                // Legacy mode hides the three fields entirely
                if (!pcie11_mode) begin
                    rd_d[`TARGET_SPEED_MSB:`TARGET_SPEED_LSB] = tls_q;
                    rd_d[`ENTER_COMPLIANCE_POS] = enter_compliance_bit_q;
                    rd_d[`AUTONOMOUS_SPEED_DISABLE_POS] = autonomous_speed_disable_q;
                end
            end
            `POWER_MGMT_CAPABILITY_HEADER_IDX: begin
                rd_d[`CAP_ID_MSB:`CAP_ID_LSB] = `CAP_ID_VALUE;
                rd_d[`NEXT_PTR_MSB:`NEXT_PTR_LSB] = next_ptr_q;
                rd_d[`CAP_VERSION_MSB:`CAP_VERSION_LSB] = `CAP_VERSION_VALUE;
                rd_d[`PM_CLOCK_REQ_POS] = 1'b0;
                rd_d[`PM_EVENT_MSB:`PM_EVENT_LSB] = pm_event_q;
            end
            default: begin
                // Always-zero registers answer with zeros, anything else with an error
                hit_d = zero_reg_hit;
            end
        endcase
    end

    // ==========================================
    // Register bus answer
    // One wait state: pready rises in the second access cycle
    // prdata is left alone between answers, so a slow master may still read it
    always @(posedge mclk) begin
        if (srst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (access & ~pready) begin
            pready <= 1'b1;
            pslverr <= ~hit_d;
            prdata <= (pwrite | ~hit_d) ? 32'h0000_0000 : rd_d;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ==========================================
    // Strap-dependent defaults load one edge after reset release
    // so a strap still settling during reset is never caught half-way
    always @(posedge mclk) begin
        if (srst) begin
            init_q <= 1'b1;
        end else begin
            init_q <= 1'b0;
        end
    end

    lockable_field #(
        .WIDTH(8)
    ) next_ptr_field (
        .mclk(mclk),
        .srst(srst),
        .load_default(init_q),
        .default_value(next_ptr_default),
        .wr_en(pm_fields_wr),
        .wr_data(pwdata[`NEXT_PTR_MSB:`NEXT_PTR_LSB]),
        .value_q(next_ptr_q)
    );

    lockable_field #(
        .WIDTH(5)
    ) pm_event_field (
        .mclk(mclk),
        .srst(srst),
        .load_default(init_q),
        .default_value(`PM_EVENT_RESET),
        .wr_en(pm_fields_wr),
        .wr_data(pwdata[`PM_EVENT_MSB:`PM_EVENT_LSB]),
        .value_q(pm_event_q)
    );

    // ==========================================
    // Link control second storage
    // Hot reset clears the plain fields; the compliance bit is sticky and only a write,
    // the fundamental reset or legacy mode clears it. A write in the same cycle as a hot reset
    // wins, so software never loses a value it has just been told was taken.
    always @(posedge mclk) begin
        if (srst) begin
            tls_q <= `TARGET_SPEED_RESET;
        end else if (pcie11_mode) begin
            tls_q <= `TARGET_SPEED_RESET;
        end else if (lctl2_wr) begin
            tls_q <= pwdata[`TARGET_SPEED_MSB:`TARGET_SPEED_LSB];
        end else if (hot_reset) begin
            tls_q <= `TARGET_SPEED_RESET;
        end
    end

    always @(posedge mclk) begin
        if (srst) begin
            autonomous_speed_disable_q <= 1'b0;
        end else if (pcie11_mode) begin
            autonomous_speed_disable_q <= 1'b0;
        end else if (lctl2_wr) begin
            autonomous_speed_disable_q <= pwdata[`AUTONOMOUS_SPEED_DISABLE_POS];
        end else if (hot_reset) begin
            autonomous_speed_disable_q <= 1'b0;
        end
    end

    // No hot reset branch: the bit must survive the hot reset that it arms
    always @(posedge mclk) begin
        if (srst) begin
            enter_compliance_bit_q <= 1'b0;
        end else if (pcie11_mode) begin
            enter_compliance_bit_q <= 1'b0;
        end else if (lctl2_wr) begin
            enter_compliance_bit_q <= pwdata[`ENTER_COMPLIANCE_POS];
        end
    end

    // ==========================================
    // Link training view
    // Plain copies of the stored fields, one edge behind storage
    always @(posedge mclk) begin
        if (srst) begin
            target_speed <= 4'h0;
            enter_compliance_bit <= 1'b0;
            autonomous_speed_disable <= 1'b0;
        end else begin
            target_speed <= tls_q;
            enter_compliance_bit <= enter_compliance_bit_q;
            autonomous_speed_disable <= autonomous_speed_disable_q;
        end
    end

    // Only codes 1 and 2 name a speed
    always @(posedge mclk) begin
        if (srst) begin
            target_speed_reserved <= 1'b0;
        end else begin
            target_speed_reserved <= (tls_q != `SPEED_GEN1) & (tls_q != `SPEED_GEN2);
        end
    end

    // On a downstream port only the 5 Gbps code adds the second rate; anything else falls
    // back to the lowest rate, while an upstream port advertises all it is capable of
    always @(posedge mclk) begin
        if (srst) begin
            advertise_gen1 <= 1'b1;
            advertise_gen2 <= 1'b0;
        end else begin
            advertise_gen1 <= 1'b1;
            if (is_downstream) begin
                advertise_gen2 <= GEN2_CAPABLE & (tls_q == `SPEED_GEN2);
            end else begin
                advertise_gen2 <= GEN2_CAPABLE;
            end
        end
    end

    // Compliance speed follows the field on either port direction
    always @(posedge mclk) begin
        if (srst) begin
            compliance_gen1 <= 1'b0;
            compliance_gen2 <= 1'b0;
        end else begin
            compliance_gen1 <= (tls_q != `SPEED_GEN2) | ~GEN2_CAPABLE;
            compliance_gen2 <= (tls_q == `SPEED_GEN2) & GEN2_CAPABLE;
        end
    end

    // Compliance is armed by a hot reset while the sticky bit is set
    // Clearing the bit or entering legacy mode drops compliance at once
    always @(posedge mclk) begin
        if (srst) begin
            compliance_active <= 1'b0;
        end else if (pcie11_mode | ~enter_compliance_bit_q) begin
            compliance_active <= 1'b0;
        end else if (hot_reset) begin
            compliance_active <= 1'b1;
        end
    end

    // ==========================================
    // Autonomous speed change gate
    // With the disable bit set only a reduction for an unreliable link passes;
    // a refusal is reported so training can stay at the current rate
    always @(posedge mclk) begin
        if (srst) begin
            speed_change_grant <= 1'b0;
            speed_change_refused <= 1'b0;
        end else begin
            speed_change_grant <= speed_change_req & ~(autonomous_speed_disable_q & speed_raise);
            speed_change_refused <= autonomous_speed_disable_q & speed_raise;
        end
    end
endmodule // link_ctl2_pm_regs

// ===== verification/link_ctl2_pm_checker.sv
// Port assertions for the link control 2 and power management register bank
`timescale 1ns/1ns
// ==========================================
// Checker
module link_ctl2_pm_checker #(
    parameter GEN2_CAPABLE = 1'b0
) (
    input wire mclk,
    input wire srst,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    input wire pcie11_mode,
    input wire hot_reset,
    input wire speed_change_req,
    input wire speed_change_lower,
    input wire [3:0] target_speed,
    input wire enter_compliance_bit,
    input wire autonomous_speed_disable,
    input wire advertise_gen1,
    input wire advertise_gen2,
    input wire compliance_gen2,
    input wire target_speed_reserved,
    input wire compliance_active,
    input wire speed_change_grant,
    input wire speed_change_refused
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    sequence s_taken; psel && penable && !pready; endsequence
    sequence s_legacy; pcie11_mode [*3]; endsequence
    // Field copies lag storage, so only a settled field is judged
    sequence s_quiet_speed; (!srst && $stable(target_speed)) [*4]; endsequence
    AST_ONE_WAIT: assert property (s_taken |=> pready ##1 !pready)
        else $error("pready not a single pulse after one wait state");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("pslverr outside an answer");
    AST_LOWER_GRANTED: assert property (
        speed_change_req && speed_change_lower |=> speed_change_grant && !speed_change_refused)
        else $error("speed reduction not granted");
    AST_REFUSE_CAUSE: assert property (
        speed_change_refused |-> $past(speed_change_req) && !$past(speed_change_lower))
        else $error("refusal without a raising request");
    AST_LEGACY_ZERO: assert property (s_legacy |-> target_speed == 4'h0 &&
        !enter_compliance_bit && !autonomous_speed_disable && !compliance_active)
        else $error("link fields not zero in legacy mode");
    AST_GEN1_ONLY: assert property ((GEN2_CAPABLE == 0) |->
        advertise_gen1 && !advertise_gen2 && !compliance_gen2)
        else $error("second speed advertised on a first speed port");
    AST_SPEED_DECODE: assert property (s_quiet_speed |->
        target_speed_reserved == !(target_speed == 4'h1 || target_speed == 4'h2))
        else $error("reserved speed flag wrong");
    AST_HOT_COMPLY: assert property (hot_reset && enter_compliance_bit &&
        !pcie11_mode && !$past(pcie11_mode) && !pready && !$past(pready) |=> compliance_active)
        else $error("hot reset with compliance set did not enter compliance");
endmodule // link_ctl2_pm_checker

bind link_ctl2_pm_regs link_ctl2_pm_checker #(.GEN2_CAPABLE(GEN2_CAPABLE)) chk_i (
    .mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .pcie11_mode(pcie11_mode), .hot_reset(hot_reset),
    .speed_change_req(speed_change_req), .speed_change_lower(speed_change_lower),
    .target_speed(target_speed), .enter_compliance_bit(enter_compliance_bit),
    .autonomous_speed_disable(autonomous_speed_disable), .advertise_gen1(advertise_gen1),
    .advertise_gen2(advertise_gen2), .compliance_gen2(compliance_gen2),
    .target_speed_reserved(target_speed_reserved), .compliance_active(compliance_active),
    .speed_change_grant(speed_change_grant), .speed_change_refused(speed_change_refused));

// ===== verification/link_trainer_model.sv
// Stand-in for the port's link training logic
`timescale 1ns/1ns
// ==========================================
// Training side
module link_trainer_model (
    input wire mclk,
    input wire req_cmd,
    input wire lower_cmd,
    input wire hot_cmd,
    output logic speed_change_req = 1'b0,
    output logic speed_change_lower = 1'b0,
    output logic hot_reset = 1'b0
);
    always @(posedge mclk) begin
        speed_change_req <= req_cmd;
        // The qualifier means nothing without a request, so it is left wandering
        speed_change_lower <= req_cmd ? lower_cmd : ~speed_change_lower;
        hot_reset <= hot_cmd;
    end
endmodule // link_trainer_model

// ===== verification/link_ctl2_pm_regs_tb.sv
// Self-checking bench for the link control 2 and power management register bank
`timescale 1ns/1ns
`include "link_ctl2_pm_defs.vh"
// ==========================================
// Bench
module link_ctl2_pm_regs_tb;
    logic mclk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, is_downstream = 1'b0, pcie11_mode = 1'b0, cfg_write_unlock = 1'b0;
    logic req_cmd = 1'b0, lower_cmd = 1'b0, hot_cmd = 1'b0;
    logic hot_reset, speed_change_req, speed_change_lower, enter_compliance_bit;
    logic [3:0] target_speed;
    logic autonomous_speed_disable, advertise_gen1, advertise_gen2, compliance_gen1;
    logic compliance_gen2, target_speed_reserved, compliance_active;
    logic speed_change_grant, speed_change_refused;
    logic [32:0] expq[$];
    logic [9:0] zero_idx[9] = '{`DEVICE_CAPABILITIES_SECOND_IDX, `DEVICE_CONTROL_SECOND_IDX,
        `DEVICE_STATUS_SECOND_IDX, `LINK_CAPABILITIES_SECOND_IDX, `LINK_STATUS_SECOND_IDX,
        `SLOT_CAPABILITIES_SECOND_IDX, `SLOT_CONTROL_SECOND_IDX, `SLOT_STATUS_SECOND_IDX,
        `SLOT_STATUS_SECOND_IDX};
    int fails = 0, checks_done = 0;
    always #5 mclk = ~mclk;
    link_ctl2_pm_regs link_ctl2_pm_regs_i (.mclk(mclk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .is_downstream(is_downstream),
        .pcie11_mode(pcie11_mode), .cfg_write_unlock(cfg_write_unlock), .hot_reset(hot_reset),
        .speed_change_req(speed_change_req), .speed_change_lower(speed_change_lower),
        .target_speed(target_speed), .enter_compliance_bit(enter_compliance_bit),
        .autonomous_speed_disable(autonomous_speed_disable), .advertise_gen1(advertise_gen1),
        .advertise_gen2(advertise_gen2), .compliance_gen1(compliance_gen1),
        .compliance_gen2(compliance_gen2), .target_speed_reserved(target_speed_reserved),
        .compliance_active(compliance_active), .speed_change_grant(speed_change_grant),
        .speed_change_refused(speed_change_refused));
    link_trainer_model link_trainer_model_i (.mclk(mclk), .req_cmd(req_cmd),
        .lower_cmd(lower_cmd), .hot_cmd(hot_cmd), .speed_change_req(speed_change_req),
        .speed_change_lower(speed_change_lower), .hot_reset(hot_reset));
    task check(input logic [32:0] got, input logic [32:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task report_and_stop;
        $display("Counts: %0d checks, %0d mismatches", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task do_reset;
        srst <= 1'b1;
        repeat (10) @(posedge mclk);
        srst <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask
    // Expected {pslverr, prdata} is queued; the monitor pairs it with the answer
    task apb(input logic w, input logic [9:0] idx, input logic [31:0] d, input logic [32:0] e);
        int n;
        expq.push_back(e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            report_and_stop;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    always @(posedge mclk) begin
        if (!srst && pready === 1'b1) begin
            check({pslverr, prdata}, expq.size() ? expq.pop_front() : ~{pslverr, prdata});
        end
    end
    initial begin
        logic [31:0] r;
        void'($urandom(32'h042b));
        do_reset;
        foreach (zero_idx[i]) apb(1'b0, zero_idx[i], 32'h0, 33'h0);
        apb(1'b0, `POWER_MGMT_CAPABILITY_HEADER_IDX, 32'h0, 33'h0c8030001);
        check({28'h0, advertise_gen1, advertise_gen2, compliance_gen1, compliance_gen2,
            target_speed_reserved}, 33'h15);
        $display("test reset image done");
        foreach (zero_idx[i]) begin
            apb(1'b1, zero_idx[i], $urandom, 33'h0);
            apb(1'b0, zero_idx[i], 32'h0, 33'h0);
        end
        apb(1'b1, 10'h000, $urandom, 33'h100000000);
        apb(1'b0, 10'h3ff, 32'h0, 33'h100000000);
        $display("test zero and unmapped done");
        r = $urandom;
        apb(1'b1, `LINK_CONTROL_SECOND_IDX, {r[31:6], 6'h31}, 33'h0);
        apb(1'b0, `LINK_CONTROL_SECOND_IDX, 32'h0, 33'h31);
        @(negedge mclk);
        check({26'h0, target_speed, enter_compliance_bit, autonomous_speed_disable,
            target_speed_reserved}, 33'h0e);
        @(posedge mclk);
        req_cmd <= 1'b1;
        @(posedge mclk);
        lower_cmd <= 1'b1;
        @(posedge mclk);
        req_cmd <= 1'b0;
        @(negedge mclk);
        check({31'h0, speed_change_grant, speed_change_refused}, 33'h1);
        @(negedge mclk);
        check({31'h0, speed_change_grant, speed_change_refused}, 33'h2);
        $display("test speed gate done");
        @(posedge mclk);
        hot_cmd <= 1'b1;
        @(posedge mclk);
        hot_cmd <= 1'b0;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        check({26'h0, compliance_active, enter_compliance_bit, autonomous_speed_disable,
            target_speed}, 33'h60);
        @(posedge mclk);
        apb(1'b0, `LINK_CONTROL_SECOND_IDX, 32'h0, 33'h10);
        req_cmd <= 1'b1;
        lower_cmd <= 1'b0;
        @(posedge mclk);
        req_cmd <= 1'b0;
        @(posedge mclk);
        @(negedge mclk);
        check({31'h0, speed_change_grant, speed_change_refused}, 33'h2);
        $display("test compliance entry done");
        pcie11_mode <= 1'b1;
        apb(1'b1, `LINK_CONTROL_SECOND_IDX, 32'h31, 33'h0);
        apb(1'b0, `LINK_CONTROL_SECOND_IDX, 32'h0, 33'h0);
        check({31'h0, compliance_active, enter_compliance_bit}, 33'h0);
        pcie11_mode <= 1'b0;
        $display("test legacy mode done");
        is_downstream <= 1'b1;
        do_reset;
        apb(1'b0, `POWER_MGMT_CAPABILITY_HEADER_IDX, 32'h0, 33'h0c803d001);
        apb(1'b1, `POWER_MGMT_CAPABILITY_HEADER_IDX, 32'h57ffabff, 33'h0);
        apb(1'b0, `POWER_MGMT_CAPABILITY_HEADER_IDX, 32'h0, 33'h0c803d001);
        cfg_write_unlock <= 1'b1;
        apb(1'b1, `POWER_MGMT_CAPABILITY_HEADER_IDX, 32'h57ffabff, 33'h0);
        apb(1'b0, `POWER_MGMT_CAPABILITY_HEADER_IDX, 32'h0, 33'h05003ab01);
        $display("test capability header done");
        report_and_stop;
    end
endmodule // link_ctl2_pm_regs_tb
